// ==== sirq_pkg.sv ====
/*
 * Package for the shared interrupt multiplexer and trap priority block:
 * register offsets, field layout, source positions, trap vectors and numbers.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package sirq_pkg;
	localparam int          SIRQ_AW          = 4;
	localparam int          SIRQ_DW          = 16;
	localparam logic [3:0]  SIRQ_OFS_SEL0    = 4'h0;
	localparam logic [3:0]  SIRQ_OFS_SEL1    = 4'h1;
	localparam logic [3:0]  SIRQ_OFS_SEL2    = 4'h2;
	localparam logic [3:0]  SIRQ_OFS_SEL3    = 4'h3;
	localparam logic [3:0]  SIRQ_OFS_TRAPF   = 4'h4;
	localparam logic [3:0]  SIRQ_OFS_TRAP    = 4'h5;
	localparam int          SIRQ_EN_LSB      = 8;
	localparam int          SIRQ_FLAG_LSB    = 0;
	localparam logic [15:0] SIRQ_SEL_RESET   = 16'h0000;
	localparam logic [15:0] SIRQ_TRAPF_RESET = 16'h0000;
	// source bit positions on vectors 0..2; bit 0 is PWM on vector 2
	localparam int          SRC_CAN          = 0;
	localparam int          SRC_I2C_RX       = 1;
	localparam int          SRC_I2C_TX       = 2;
	localparam int          SRC_SSC_RX       = 3;
	localparam int          SRC_SSC_TX       = 4;
	localparam int          SRC_ASC_RX       = 5;
	localparam int          SRC_ASC_TX       = 6;
	localparam int          SRC_ASC_TB       = 7;
	// source bit positions on vector 3
	localparam int          SRC3_CAN_N1      = 0;
	localparam int          SRC3_CAN_N2      = 1;
	localparam int          SRC3_I2C_ERR     = 2;
	localparam int          SRC3_SSC_ERR     = 3;
	localparam int          SRC3_ASC_ERR     = 4;
	localparam int          SRC3_UNLOCK      = 5;
	localparam int          SRC3_PWM         = 6;
	// trap flag register bits
	localparam int          TRAPF_NMI        = 15;
	localparam int          TRAPF_STK_OVF    = 14;
	localparam int          TRAPF_STK_UNF    = 13;
	localparam int          TRAPF_UNDEF_OP   = 7;
	localparam int          TRAPF_MAC_INT    = 6;
	localparam int          TRAPF_PROT_FLT   = 3;
	localparam int          TRAPF_ILL_OPND   = 2;
	localparam int          TRAPF_ILL_INSTR  = 1;
	localparam int          TRAPF_ILL_BUS    = 0;
	// vectors and trap numbers
	localparam logic [23:0] VEC_RESET        = 24'h000000;
	localparam logic [23:0] VEC_NMI          = 24'h000008;
	localparam logic [23:0] VEC_STK_OVF      = 24'h000010;
	localparam logic [23:0] VEC_STK_UNF      = 24'h000018;
	localparam logic [23:0] VEC_CLASS_B      = 24'h000028;
	localparam logic [6:0]  TN_RESET         = 7'h00;
	localparam logic [6:0]  TN_NMI           = 7'h02;
	localparam logic [6:0]  TN_STK_OVF       = 7'h04;
	localparam logic [6:0]  TN_STK_UNF       = 7'h06;
	localparam logic [6:0]  TN_CLASS_B       = 7'h0a;
	localparam logic [6:0]  TN_RSVD_LO       = 7'h0b;
	localparam logic [6:0]  TN_RSVD_HI       = 7'h0f;
	localparam logic [3:0]  LVL_MAX          = 4'hf;
	// priority ranks, higher wins
	localparam logic [1:0]  PRIO_RESET       = 2'h3;
	localparam logic [1:0]  PRIO_CLASS_A     = 2'h2;
	localparam logic [1:0]  PRIO_CLASS_B     = 2'h1;
	localparam logic [1:0]  PRIO_NONE        = 2'h0;
	typedef enum logic [1:0] {
		SIRQ_IDLE,
		SIRQ_IN_TRAP
	} sirq_state_t;
endpackage

// ==== sirq_sel_if.sv ====
/*
 * Interface joining the top module to one shared select register slice.
 * Assumes one writer (the top) and one slice per vector.
 */
interface sirq_sel_if;
	logic        wr;
	logic [15:0] wdata;
	logic [7:0]  event_in;
	logic [15:0] value;
	logic        request;
	modport ctl (output wr, output wdata, output event_in, input value, input request);
	modport sel (input wr, input wdata, input event_in, output value, output request);
endinterface

// ==== sirq_select.sv ====
/*
 * One shared select register: enable byte high, sticky flag byte low.
 * Assumes synchronous one-cycle event pulses from the sources.
 */
module sirq_select
	import sirq_pkg::*;
#(
	parameter logic [7:0] SRC_MASK = 8'hff
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	sirq_sel_if.sel   bus
);
	logic [7:0] en_r;
	logic [7:0] flag_r;
	logic [7:0] flag_nxt;
	wire  [7:0] ev = bus.event_in & SRC_MASK;

	// set wins over a software clear in the same cycle
	always_comb begin
		flag_nxt = flag_r | ev;
		if (bus.wr) begin
			flag_nxt = (bus.wdata[SIRQ_FLAG_LSB +: 8] & SRC_MASK) | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			en_r   <= SIRQ_SEL_RESET[SIRQ_EN_LSB +: 8];
			flag_r <= SIRQ_SEL_RESET[SIRQ_FLAG_LSB +: 8];
		end else begin
			if (bus.wr) begin
				en_r <= bus.wdata[SIRQ_EN_LSB +: 8] & SRC_MASK;
			end
			flag_r <= flag_nxt;
		end
	end

	assign bus.value   = {en_r, flag_r};
	assign bus.request = |(en_r & flag_r);
endmodule

// ==== sirq_top.sv ====
/*
 * Shared peripheral interrupt multiplexer and trap prioritiser.
 * Assumes single clock, synchronous active-high reset, and a register port
 * with read data valid the cycle after the read strobe.
 */
// Summary of operation
// - four shared vectors, each a 16-bit register
// - upper byte holds per-source enables
// - lower byte holds per-source flags
// - only enabled sources request the vector
// - flags set even while masked
// - serial rx/tx sources on vectors 0-2 only
// - vector 3 errors, unlock, CAN, PWM
// - resets vector zero, trap zero, top priority
// - class A own vectors, second priority
// - class B share one vector and number
// - class B rank below class A
// - resets and hardware traps force level 15
// - each hardware trap sets its flag bit
// - hardware and reset trap service blocks interrupts, only higher or a reset preempts; software traps do not block
module sirq_top
	import sirq_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic [sirq_pkg::SIRQ_AW-1:0] addr_i,
	input  wire logic [sirq_pkg::SIRQ_DW-1:0] wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [sirq_pkg::SIRQ_DW-1:0] rdata_o,
	input  wire logic                  can_node_1_i,
	input  wire logic                  can_node_2_i,
	input  wire logic                  i2c_rx_i,
	input  wire logic                  i2c_tx_i,
	input  wire logic                  i2c_err_i,
	input  wire logic                  second_sync_serial_rx_i,
	input  wire logic                  second_sync_serial_tx_i,
	input  wire logic                  second_sync_serial_err_i,
	input  wire logic                  second_async_serial_rx_i,
	input  wire logic                  second_async_serial_tx_i,
	input  wire logic                  second_async_serial_tb_i,
	input  wire logic                  second_async_serial_err_i,
	input  wire logic                  pll_unlock_oscillator_watchdog_i,
	input  wire logic                  second_pwm_unit_ch3_i,
	output logic                       shared_vector_0_o,
	output logic                       shared_vector_1_o,
	output logic                       shared_vector_2_o,
	output logic                       shared_vector_3_o,
	input  wire logic                  hw_reset_i,
	input  wire logic                  sw_reset_i,
	input  wire logic                  wdt_overflow_i,
	input  wire logic                  nmi_i,
	input  wire logic                  stack_overflow_i,
	input  wire logic                  stack_underflow_i,
	input  wire logic                  undefined_opcode_i,
	input  wire logic                  mac_interruption_i,
	input  wire logic                  protected_instr_fault_i,
	input  wire logic                  illegal_operand_i,
	input  wire logic                  illegal_instr_access_i,
	input  wire logic                  illegal_bus_access_i,
	input  wire logic                  sw_trap_i,
	input  wire logic [6:0]            sw_trap_number_i,
	input  wire logic [3:0]            cpu_priority_level_i,
	input  wire logic                  trap_return_i,
	output logic                       trap_take_o,
	output logic      [23:0]           trap_vector_o,
	output logic      [6:0]            trap_number_o,
	output logic      [3:0]            trap_priority_level_o,
	output logic                       trap_active_o,
	output logic                       irq_block_o
);
	////////////////////////////////////////////////////////////////////////////
	// shared select registers

	sirq_sel_if sel_bus [4] ();
	logic [15:0] trapf_r;
	logic [15:0] rdata_r;
	logic [15:0] rd_mux;

	wire [7:0] ev_v0 = {second_async_serial_tb_i, second_async_serial_tx_i,
	                    second_async_serial_rx_i, second_sync_serial_tx_i,
	                    second_sync_serial_rx_i, i2c_tx_i, i2c_rx_i, can_node_1_i};
	wire [7:0] ev_v1 = {ev_v0[7:1], can_node_2_i};
	wire [7:0] ev_v2 = {ev_v0[7:1], second_pwm_unit_ch3_i};
	wire [7:0] ev_v3 = {1'b0, second_pwm_unit_ch3_i, pll_unlock_oscillator_watchdog_i,
	                    second_async_serial_err_i, second_sync_serial_err_i, i2c_err_i,
	                    can_node_2_i, can_node_1_i};

	wire wr_sel0 = wr_i && (addr_i == SIRQ_OFS_SEL0);
	wire wr_sel1 = wr_i && (addr_i == SIRQ_OFS_SEL1);
	wire wr_sel2 = wr_i && (addr_i == SIRQ_OFS_SEL2);
	wire wr_sel3 = wr_i && (addr_i == SIRQ_OFS_SEL3);
	wire wr_trapf = wr_i && (addr_i == SIRQ_OFS_TRAPF);

	// vectors 0..2 carry serial rx/tx; vector 3 carries errors
	assign sel_bus[0].wr       = wr_sel0;
	assign sel_bus[1].wr       = wr_sel1;
	assign sel_bus[2].wr       = wr_sel2;
	assign sel_bus[3].wr       = wr_sel3;
	assign sel_bus[0].wdata    = wdata_i;
	assign sel_bus[1].wdata    = wdata_i;
	assign sel_bus[2].wdata    = wdata_i;
	assign sel_bus[3].wdata    = wdata_i;
	assign sel_bus[0].event_in = ev_v0;
	assign sel_bus[1].event_in = ev_v1;
	assign sel_bus[2].event_in = ev_v2;
	assign sel_bus[3].event_in = ev_v3;

	sirq_select #(.SRC_MASK(8'hff)) u_sel0 (.clk_i(clk_i), .reset_i(reset_i), .bus(sel_bus[0]));
	sirq_select #(.SRC_MASK(8'hff)) u_sel1 (.clk_i(clk_i), .reset_i(reset_i), .bus(sel_bus[1]));
	sirq_select #(.SRC_MASK(8'hff)) u_sel2 (.clk_i(clk_i), .reset_i(reset_i), .bus(sel_bus[2]));
	sirq_select #(.SRC_MASK(8'h7f)) u_sel3 (.clk_i(clk_i), .reset_i(reset_i), .bus(sel_bus[3]));

	assign shared_vector_0_o = sel_bus[0].request;
	assign shared_vector_1_o = sel_bus[1].request;
	assign shared_vector_2_o = sel_bus[2].request;
	assign shared_vector_3_o = sel_bus[3].request;

	////////////////////////////////////////////////////////////////////////////
	// trap prioritisation

	wire any_reset = hw_reset_i | sw_reset_i | wdt_overflow_i;
	wire any_a     = nmi_i | stack_overflow_i | stack_underflow_i;
	wire any_b     = undefined_opcode_i | mac_interruption_i | protected_instr_fault_i |
	                 illegal_operand_i | illegal_instr_access_i | illegal_bus_access_i;

	// highest pending hardware class
	wire [1:0] req_prio = any_reset ? PRIO_RESET :
	                      any_a     ? PRIO_CLASS_A :
	                      any_b     ? PRIO_CLASS_B : PRIO_NONE;

	wire [23:0] hw_vec = any_reset         ? VEC_RESET :
	                     nmi_i             ? VEC_NMI :
	                     stack_overflow_i  ? VEC_STK_OVF :
	                     stack_underflow_i ? VEC_STK_UNF : VEC_CLASS_B;
	wire [6:0]  hw_tn  = any_reset         ? TN_RESET :
	                     nmi_i             ? TN_NMI :
	                     stack_overflow_i  ? TN_STK_OVF :
	                     stack_underflow_i ? TN_STK_UNF : TN_CLASS_B;

	sirq_state_t state_r;
	sirq_state_t state_nxt;
	logic [1:0]  cur_prio_r;
	logic [1:0]  cur_prio_nxt;

	// resets always win; otherwise only a strictly higher class preempts
	wire hw_take = (req_prio != PRIO_NONE) &&
	               (any_reset || (state_r == SIRQ_IDLE) || (req_prio > cur_prio_r));
	// reserved numbers are refused
	wire sw_rsvd = (sw_trap_number_i >= TN_RSVD_LO) && (sw_trap_number_i <= TN_RSVD_HI);
	wire sw_take = sw_trap_i && !sw_rsvd && (state_r == SIRQ_IDLE) && (req_prio == PRIO_NONE);
	wire [23:0] sw_vec = {15'h0000, sw_trap_number_i, 2'b00};

	always_comb begin
		state_nxt    = state_r;
		cur_prio_nxt = cur_prio_r;
		case (state_r)
			SIRQ_IDLE: begin
				if (hw_take) begin
					state_nxt    = SIRQ_IN_TRAP;
					cur_prio_nxt = req_prio;
				end
			end
			SIRQ_IN_TRAP: begin
				if (hw_take) begin
					cur_prio_nxt = req_prio;
				end else if (trap_return_i) begin
					state_nxt    = SIRQ_IDLE;
					cur_prio_nxt = PRIO_NONE;
				end
			end
			default: begin
				state_nxt    = SIRQ_IDLE;
				cur_prio_nxt = PRIO_NONE;
			end
		endcase
	end

	// trap flags: hardware set wins over software clear
	wire [15:0] trapf_set = ({15'h0000, illegal_bus_access_i}    << TRAPF_ILL_BUS)   |
	                        ({15'h0000, illegal_instr_access_i}  << TRAPF_ILL_INSTR) |
	                        ({15'h0000, illegal_operand_i}       << TRAPF_ILL_OPND)  |
	                        ({15'h0000, protected_instr_fault_i} << TRAPF_PROT_FLT)  |
	                        ({15'h0000, mac_interruption_i}      << TRAPF_MAC_INT)   |
	                        ({15'h0000, undefined_opcode_i}      << TRAPF_UNDEF_OP)  |
	                        ({15'h0000, stack_underflow_i}       << TRAPF_STK_UNF)   |
	                        ({15'h0000, stack_overflow_i}        << TRAPF_STK_OVF)   |
	                        ({15'h0000, nmi_i}                   << TRAPF_NMI);
	wire [15:0] trapf_nxt = (wr_trapf ? (trapf_r & wdata_i) : trapf_r) | trapf_set;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r    <= SIRQ_IDLE;
			cur_prio_r <= PRIO_NONE;
			trapf_r    <= SIRQ_TRAPF_RESET;
		end else begin
			state_r    <= state_nxt;
			cur_prio_r <= cur_prio_nxt;
			trapf_r    <= trapf_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			trap_take_o           <= 1'b0;
			trap_vector_o         <= VEC_RESET;
			trap_number_o         <= TN_RESET;
			trap_priority_level_o <= 4'h0;
		end else begin
			trap_take_o <= hw_take | sw_take;
			if (hw_take) begin
				trap_vector_o         <= hw_vec;
				trap_number_o         <= hw_tn;
				trap_priority_level_o <= LVL_MAX;
			end else if (sw_take) begin
				trap_vector_o         <= sw_vec;
				trap_number_o         <= sw_trap_number_i;
				trap_priority_level_o <= cpu_priority_level_i;
			end
		end
	end

	assign trap_active_o = (state_r == SIRQ_IN_TRAP);
	assign irq_block_o   = (state_r == SIRQ_IN_TRAP);

	////////////////////////////////////////////////////////////////////////////
	// register read port

	wire [15:0] trap_status = {13'h0000, trap_active_o, cur_prio_r};

	always_comb begin
		case (addr_i)
			SIRQ_OFS_SEL0: rd_mux = sel_bus[0].value;
			SIRQ_OFS_SEL1: rd_mux = sel_bus[1].value;
			SIRQ_OFS_SEL2: rd_mux = sel_bus[2].value;
			SIRQ_OFS_SEL3: rd_mux = sel_bus[3].value;
			SIRQ_OFS_TRAPF: rd_mux = trapf_r;
			SIRQ_OFS_TRAP: rd_mux = trap_status;
			default:       rd_mux = 16'h0000;
		endcase
	end

	// flag byte readable for polling and source identification
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rd_i ? rd_mux : 16'h0000;
		end
	end

	assign rdata_o = rdata_r;
endmodule

// ==== sirq_top_properties.sv ====
/*
 * Concurrent checks on the ports of the shared interrupt mux and trap block.
 * Assumes it is bound onto sirq_top, one clock, reset_i synchronous.
 */
module sirq_chk
	import sirq_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic [SIRQ_AW-1:0]   addr_i,
	input  wire logic                 rd_i,
	input  wire logic [SIRQ_DW-1:0]   rdata_o,
	input  wire logic                 shared_vector_0_o,
	input  wire logic                 shared_vector_3_o,
	input  wire logic                 hw_reset_i,
	input  wire logic                 sw_reset_i,
	input  wire logic                 wdt_overflow_i,
	input  wire logic                 nmi_i,
	input  wire logic                 sw_trap_i,
	input  wire logic [6:0]           sw_trap_number_i,
	input  wire logic [3:0]           cpu_priority_level_i,
	input  wire logic                 trap_return_i,
	input  wire logic                 trap_take_o,
	input  wire logic [23:0]          trap_vector_o,
	input  wire logic [6:0]           trap_number_o,
	input  wire logic [3:0]           trap_priority_level_o,
	input  wire logic                 trap_active_o,
	input  wire logic                 irq_block_o
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic any_rst = hw_reset_i | sw_reset_i | wdt_overflow_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside read answer");
	AST_UNMAPPED: assert property (rd_i && addr_i > 4'h5 |=> rdata_o == 16'h0000)
		else $error("unmapped index read not zero");
	AST_VEC0: assert property ($past(rd_i) && $past(addr_i) == 4'h0
		&& |(rdata_o[15:8] & rdata_o[7:0]) |-> shared_vector_0_o)
		else $error("vector 0 low with enabled flag");
	AST_VEC3: assert property ($past(rd_i) && $past(addr_i) == 4'h3
		&& |(rdata_o[15:8] & rdata_o[7:0]) |-> shared_vector_3_o)
		else $error("vector 3 low with enabled flag");
	AST_RESET_VEC: assert property (any_rst |=> trap_take_o && trap_vector_o == 24'h000000
		&& trap_number_o == 7'h00 && trap_priority_level_o == 4'hf)
		else $error("reset trap not taken at vector zero");
	AST_NMI_VEC: assert property (nmi_i && !trap_active_o && !any_rst |=> trap_take_o
		&& trap_vector_o == 24'h000008 && trap_number_o == 7'h02 && trap_priority_level_o == 4'hf)
		else $error("nonmaskable trap vector wrong");
	AST_SW_VEC: assert property ($past(sw_trap_i) && trap_take_o
		&& trap_number_o == $past(sw_trap_number_i) |-> trap_vector_o == {15'h0000, trap_number_o, 2'b00}
		&& trap_priority_level_o == $past(cpu_priority_level_i))
		else $error("software trap vector or level wrong");
	AST_SW_RSVD: assert property (sw_trap_i && sw_trap_number_i inside {[7'h0b:7'h0f]}
		&& !any_rst && !nmi_i |=> !trap_take_o)
		else $error("reserved trap number taken");
	AST_BLOCK: assert property ($past(nmi_i) && trap_take_o |-> trap_active_o && irq_block_o)
		else $error("trap service not blocking interrupts");
	AST_HOLD: assert property (trap_active_o && !trap_return_i |=> trap_active_o)
		else $error("trap service ended without return");
	////////////////////////////////////////////////////////////////
	COV_RESET: cover property (hw_reset_i ##1 trap_take_o);
	COV_PREEMPT: cover property (trap_active_o && nmi_i ##1 trap_take_o);
	COV_VEC3: cover property (shared_vector_3_o);
endmodule

// ==== sirq_far_model.sv ====
/*
 * Far side: peripheral request sources and the CPU core trap lines.
 * Assumes the bench commands one event per bit, bit order as the bench.
 */
module sirq_far_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [27:0] ev_i,
	output logic      [27:0] pins_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// pins follow the command one clock later
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pins_o <= '0;
		end else begin
			pins_o <= ev_i;
		end
	end
endmodule

// ==== sirq_top_tb.sv ====
/*
 * Self-checking bench for sirq_top: register port, shared vectors, traps.
 * Assumes sirq_far_model drives all event inputs.
 */
module sirq_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sirq_pkg::*;
	logic               clk_i = 1'b0;
	logic               reset_i = 1'b1;
	logic               wr_i = 1'b0;
	logic               rd_i = 1'b0;
	logic [SIRQ_AW-1:0] addr_i = '0;
	logic [SIRQ_DW-1:0] wdata_i = '0;
	logic [SIRQ_DW-1:0] rdata_o;
	logic [27:0]        ev = '0;
	logic [27:0]        pins;
	logic [6:0]         sw_trap_number_i = 7'h00;
	logic [3:0]         cpu_priority_level_i = 4'h5;
	logic [6:0]         trap_number_o;
	logic [3:0]         trap_priority_level_o;
	logic [23:0]        trap_vector_o;
	logic shared_vector_0_o, shared_vector_1_o, shared_vector_2_o, shared_vector_3_o;
	logic trap_take_o, trap_active_o, irq_block_o, can_node_1_i, can_node_2_i;
	logic i2c_rx_i, i2c_tx_i, i2c_err_i, pll_unlock_oscillator_watchdog_i;
	logic second_sync_serial_rx_i, second_sync_serial_tx_i, second_sync_serial_err_i;
	logic second_async_serial_rx_i, second_async_serial_tx_i, second_async_serial_tb_i;
	logic second_async_serial_err_i, second_pwm_unit_ch3_i, hw_reset_i, sw_reset_i;
	logic wdt_overflow_i, nmi_i, stack_overflow_i, stack_underflow_i, undefined_opcode_i;
	logic mac_interruption_i, protected_instr_fault_i, illegal_operand_i;
	logic illegal_instr_access_i, illegal_bus_access_i, sw_trap_i, trap_return_i;
	wire  [3:0]         vecs = {shared_vector_3_o, shared_vector_2_o, shared_vector_1_o,
		shared_vector_0_o};
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	assign {trap_return_i, sw_trap_i, illegal_bus_access_i, illegal_instr_access_i,
		illegal_operand_i, protected_instr_fault_i, mac_interruption_i, undefined_opcode_i,
		stack_underflow_i, stack_overflow_i, nmi_i, wdt_overflow_i, sw_reset_i, hw_reset_i,
		second_pwm_unit_ch3_i, pll_unlock_oscillator_watchdog_i, second_async_serial_err_i,
		second_async_serial_tb_i, second_async_serial_tx_i, second_async_serial_rx_i,
		second_sync_serial_err_i, second_sync_serial_tx_i, second_sync_serial_rx_i,
		i2c_err_i, i2c_tx_i, i2c_rx_i, can_node_2_i, can_node_1_i} = pins;
	sirq_top dut_u (
		.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .can_node_1_i,
		.can_node_2_i, .i2c_rx_i, .i2c_tx_i, .i2c_err_i, .second_sync_serial_rx_i,
		.second_sync_serial_tx_i, .second_sync_serial_err_i, .second_async_serial_rx_i,
		.second_async_serial_tx_i, .second_async_serial_tb_i, .second_async_serial_err_i,
		.pll_unlock_oscillator_watchdog_i, .second_pwm_unit_ch3_i, .shared_vector_0_o,
		.shared_vector_1_o, .shared_vector_2_o, .shared_vector_3_o, .hw_reset_i,
		.sw_reset_i, .wdt_overflow_i, .nmi_i, .stack_overflow_i, .stack_underflow_i,
		.undefined_opcode_i, .mac_interruption_i, .protected_instr_fault_i,
		.illegal_operand_i, .illegal_instr_access_i, .illegal_bus_access_i, .sw_trap_i,
		.sw_trap_number_i, .cpu_priority_level_i, .trap_return_i, .trap_take_o,
		.trap_vector_o, .trap_number_o, .trap_priority_level_o, .trap_active_o,
		.irq_block_o);
	sirq_far_model far_u (.clk_i, .reset_i, .ev_i(ev), .pins_o(pins));
	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [3:0] a, logic [15:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", 24'(e), 24'(rdata_o));
	endtask
	task automatic fire(int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int v3 [7] = '{0, 1, 4, 7, 11, 12, 13};
		logic [15:0] tmask [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h4000, 16'h2000,
			16'h0080, 16'h0040, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
		logic [6:0] swn [5] = '{7'h7f, 7'h20, 7'h00, 7'h0b, 7'h0f};
		logic [6:0] num;
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
		wr(4'h9, 16'hffff);
		rd(4'h9, 16'h0000);
		$display("test register reset done");
		fire(2);
		rd(4'h0, 16'h0002);
		rd(4'h1, 16'h0002);
		rd(4'h2, 16'h0002);
		rd(4'h3, 16'h0000);
		chk("vector0", 0, shared_vector_0_o);
		wr(4'h0, 16'h0202);
		chk("vector0", 1, shared_vector_0_o);
		wr(4'h0, 16'h0200);
		chk("vector0", 0, shared_vector_0_o);
		wr(4'h1, 16'h0202);
		wr(4'h2, 16'h0202);
		chk("vectors", 24'h000006, 24'(vecs));
		for (int k = 0; k < 3; k++) wr(k[3:0], 16'h0000);
		$display("test masking done");
		for (int k = 0; k < 7; k++) fire(v3[k]);
		rd(4'h3, 16'h007f);
		for (int k = 0; k < 3; k++) rd(k[3:0], 16'h0001);
		wr(4'h3, 16'h407f);
		chk("vector3", 1, shared_vector_3_o);
		rd(4'h3, 16'h407f);
		wr(4'h0, 16'h0100);
		fire(0);
		rd(4'h0, 16'h0101);
		chk("vectors", 24'h000009, 24'(vecs));
		$display("test vector map done");
		for (int i = 0; i < 12; i++) begin
			num = (i < 3) ? 7'h00 : (i < 6) ? 7'(2 * (i - 2)) : 7'h0a;
			fire(14 + i);
			chk("take", 1, trap_take_o);
			chk("vector", {15'h0000, num, 2'b00}, trap_vector_o);
			chk("number", 24'(num), 24'(trap_number_o));
			chk("level", 4'hf, trap_priority_level_o);
			if (i > 2) chk("active", 1, trap_active_o);
			if (i > 2) chk("block", 1, irq_block_o);
			rd(4'h4, tmask[i]);
			wr(4'h4, 16'h0000);
			fire(27);
			chk("active", 0, trap_active_o);
			chk("block", 0, irq_block_o);
		end
		$display("test trap table done");
		fire(17);
		rd(4'h5, 16'h0006);
		fire(18);
		chk("take", 0, trap_take_o);
		fire(20);
		chk("take", 0, trap_take_o);
		fire(26);
		chk("take", 0, trap_take_o);
		fire(14);
		chk("take", 1, trap_take_o);
		rd(4'h4, 16'hc080);
		fire(27);
		fire(21);
		fire(17);
		chk("vector", 24'h000008, trap_vector_o);
		fire(27);
		wr(4'h4, 16'h0000);
		$display("test priority done");
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_i);
			sw_trap_number_i <= swn[k];
			cpu_priority_level_i <= 4'(k + 2);
			fire(26);
			chk("take", 24'(k < 3), 24'(trap_take_o));
			if (k < 3) chk("vector", {15'h0000, swn[k], 2'b00}, trap_vector_o);
			if (k < 3) chk("level", 24'(k + 2), 24'(trap_priority_level_o));
		end
		$display("test software trap done");
		report_and_stop();
	end
endmodule
bind sirq_top sirq_chk chk_u (.clk_i, .reset_i, .addr_i, .rd_i, .rdata_o, .shared_vector_0_o,
	.shared_vector_3_o, .hw_reset_i, .sw_reset_i, .wdt_overflow_i, .nmi_i, .sw_trap_i,
	.sw_trap_number_i, .cpu_priority_level_i, .trap_return_i, .trap_take_o, .trap_vector_o,
	.trap_number_o, .trap_priority_level_o, .trap_active_o, .irq_block_o);
